// file: common/bcdcnt_pkg.sv
package bcdcnt_pkg;

    // ****************************************************************
    // Register port geometry
    // ****************************************************************
    localparam int          ADDR_W       = 3;
    localparam int          DATA_W       = 16;
    localparam logic [2:0]  REG_CTRL     = 3'h0;
    localparam logic [2:0]  REG_STATUS   = 3'h1;
    localparam logic [2:0]  REG_MASK     = 3'h2;
    localparam logic [2:0]  REG_COUNT    = 3'h3;
    localparam logic [2:0]  REG_HALF     = 3'h4;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          CTRL_FMT_BIT = 0;
    localparam int          EV_ROLL_BIT  = 0;
    localparam int          EV_OVF_BIT   = 1;
    localparam int          EV_W         = 2;
    localparam logic        CTRL_RST     = 1'b0;
    localparam logic [1:0]  MASK_RST     = 2'h0;
    localparam logic [1:0]  STATUS_RST   = 2'h0;

    // ****************************************************************
    // Counter limits
    // ****************************************************************
    localparam int          NDIG         = 4;
    localparam logic [3:0]  LIM_DEC      = 4'h9;
    localparam logic [3:0]  LIM_TIME_TEN = 4'h5;
    localparam logic [3:0]  DIG_ZERO     = 4'h0;
    localparam logic [3:0]  DIG_ONE      = 4'h1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_NS       = 50;
    localparam int          CARRY_LOW_NS = 200;
    localparam int          CARRY_LOW_CYC =
        (CARRY_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CCNT_W       = 4;
    localparam logic [3:0]  CARRY_LOAD   = 4'(CARRY_LOW_CYC);

    // ****************************************************************
    // Segment codes, bit 6 = a down to bit 0 = g, 1 = lit
    // ****************************************************************
    localparam logic [6:0]  SEG_BLANK    = 7'h00;
    localparam logic [9:0][6:0] SEG_TBL  = {
        7'h7b, 7'h7f, 7'h70, 7'h5f, 7'h5b,
        7'h33, 7'h79, 7'h6d, 7'h30, 7'h7e
    };

    // ****************************************************************
    // Carried groups
    // ****************************************************************
    typedef logic [NDIG-1:0][3:0] bcdcnt_digits_t;
    typedef logic [NDIG-1:0][6:0] bcdcnt_segs_t;

    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic                 prev;
        bcdcnt_digits_t       dig;
        logic                 half;
        logic [CCNT_W-1:0]    carry_cnt;
        logic                 carry;
        bcdcnt_segs_t         seg;
        logic                 half_seg;
        logic                 lz_out;
        logic                 fmt;
        logic [EV_W-1:0]      status;
        logic [EV_W-1:0]      mask;
        logic [DATA_W-1:0]    rdata;
        logic                 irq;
    } bcdcnt_state_s;

endpackage

// file: design/bcdcnt_decade.sv
`timescale 1ns/1ps

// One decade of the ripple chain: steps by one and wraps at its limit
module bcdcnt_decade
(
    input  wire logic [3:0] dig,    // Present digit
    input  wire logic       inc,    // Step request from lower stage
    input  wire logic [3:0] lim,    // Highest legal value
    output logic      [3:0] nxt,    // Next digit
    output logic            co      // Wrap carry to next stage
);

    // Wrap at or above the limit so a stray code recovers
    always_comb
    begin
        co  = inc && (dig >= lim);
        nxt = dig;
        if (co)
        begin
            nxt = bcdcnt_pkg::DIG_ZERO;
        end
        else if (inc)
        begin
            nxt = 4'(dig + bcdcnt_pkg::DIG_ONE);
        end
    end

endmodule

// file: design/bcdcnt_segdec.sv
`timescale 1ns/1ps

// Four-to-seven decoder with blanking
module bcdcnt_segdec
(
    input  wire logic [3:0] bcd,    // Digit value
    input  wire logic       blank,  // Dark the digit
    output logic      [6:0] seg     // Segment pattern, 1 = lit
);

    // Codes above nine read dark
    always_comb
    begin
        seg = bcdcnt_pkg::SEG_BLANK;
        if (!blank && bcd <= bcdcnt_pkg::LIM_DEC)
        begin
            seg = bcdcnt_pkg::SEG_TBL[bcd];
        end
    end

endmodule

// file: design/bcdcnt_top.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Each falling count edge steps the four decades by one unless held.
// [R2] Carry falls after the step that wraps the maximum to the next 10000.
// [R3] A flip-flop set by the carry lights the half digit as overflow.
// [R4] The half digit clears only while clear is low, with the counter.
// [R5] Counting and carry edges go on unchanged once the half digit is set.
// [R6] Hold low stops the first stage while the edge detector keeps running.
// [R7] Each decade is decoded to seven segments, one output per segment.
// [R8] Segment latches follow while store is low and hold while it is high.
// [R9] With the chain input high, leading zero digits are blanked.
// [R10] Chain input low or half digit set blanks none of the four digits, so zero digits are shown.
// [R11] Chain output is high only when all four digits are blanked.
// [R12] Cascades feed the upper device's chain output to the lower's input.
// [R13] Undriven store, clear, hold and chain inputs count as high.
// [R14] While clear is low all four decades are forced to zero.
// [R15] The count input is synchronised and each fall steps at most once.
module bcdcnt_top
(
    input  wire logic                            clk_sys,   // System clock
    input  wire logic                            nrst,      // Async reset
    input  wire logic                            cnt_in,    // Count input
    input  wire logic                            hold_n,    // Low holds count
    input  wire logic                            clr_n,     // Low clears count
    input  wire logic                            store_n,   // Low loads latches
    input  wire logic                            lz_in,     // Blank chain in
    output logic                                 carry_out, // Carry, falls
    output logic                                 lz_out,    // Blank chain out
    output logic [bcdcnt_pkg::NDIG*7-1:0]        seg_out,   // Digit segments
    output logic                                 half_seg,  // Half digit
    input  wire logic [bcdcnt_pkg::ADDR_W-1:0]   reg_addr,  // Register address
    input  wire logic [bcdcnt_pkg::DATA_W-1:0]   reg_wdata, // Write data
    input  wire logic                            reg_we,    // Write strobe
    input  wire logic                            reg_re,    // Read strobe
    output logic [bcdcnt_pkg::DATA_W-1:0]        reg_rdata, // Read data
    output logic                                 irq        // Interrupt level
);

    // ****************************************************************
    // State
    // ****************************************************************
    bcdcnt_pkg::bcdcnt_state_s st_r;
    bcdcnt_pkg::bcdcnt_state_s st_nxt;

    // Ripple chain wires
    bcdcnt_pkg::bcdcnt_digits_t dig_step;
    logic [bcdcnt_pkg::NDIG:0]  chain;
    logic [bcdcnt_pkg::NDIG-1:0][3:0] lim;

    // Blanking and decoder wires
    logic [bcdcnt_pkg::NDIG-1:0] blank;
    bcdcnt_pkg::bcdcnt_segs_t    seg_dec;

    // Count edge and event wires
    logic                        fall;
    logic                        adv;
    logic                        roll;
    logic [bcdcnt_pkg::EV_W-1:0] ev;

    // ****************************************************************
    // Count edge detection
    // ****************************************************************

    // Falling edge seen between the second sync stage and its delay
    assign fall = st_r.prev & ~st_r.sync2;                    // [R15]

    // Hold gates the step, never the sampling of the count input
    assign adv  = fall & hold_n & clr_n;                      // [R1] [R6]

    // ****************************************************************
    // Decade chain
    // ****************************************************************

    // Tens positions wrap at five in time format
    always_comb
    begin
        for (int i = 0; i < bcdcnt_pkg::NDIG; i++)
        begin
            lim[i] = bcdcnt_pkg::LIM_DEC;
            if (st_r.fmt && (i % 2 == 1))
            begin
                lim[i] = bcdcnt_pkg::LIM_TIME_TEN;            // [R2]
            end
        end
    end

    assign chain[0] = adv;

    // Four decades rippling their carries upward
    genvar g;
    generate
        for (g = 0; g < bcdcnt_pkg::NDIG; g++)
        begin : gen_dec
            bcdcnt_decade u_decade
            (
                .dig (st_r.dig[g]),
                .inc (chain[g]),
                .lim (lim[g]),
                .nxt (dig_step[g]),
                .co  (chain[g+1])
            );
        end
    endgenerate

    // Top decade wrapping means the count passed its maximum
    assign roll = chain[bcdcnt_pkg::NDIG];                    // [R2]

    // ****************************************************************
    // Blanking and decoding
    // ****************************************************************

    // Zero detect walks down from the top digit
    always_comb
    begin
        logic run;
        run = lz_in & ~st_r.half;                             // [R9] [R10]
        for (int i = bcdcnt_pkg::NDIG - 1; i >= 0; i--)
        begin
            run      = run && (st_r.dig[i] == bcdcnt_pkg::DIG_ZERO);
            blank[i] = run;                                   // [R9]
        end
    end

    // One decoder per decade
    generate
        for (g = 0; g < bcdcnt_pkg::NDIG; g++)
        begin : gen_seg
            bcdcnt_segdec u_segdec
            (
                .bcd   (st_r.dig[g]),
                .blank (blank[g]),
                .seg   (seg_dec[g])                           // [R7]
            );
        end
    endgenerate

    // ****************************************************************
    // Events
    // ****************************************************************

    // Wrap and first overflow raise status bits
    always_comb
    begin
        ev                          = '0;
        ev[bcdcnt_pkg::EV_ROLL_BIT] = roll;
        ev[bcdcnt_pkg::EV_OVF_BIT]  = roll & ~st_r.half;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // All state updates in one place
    always_comb
    begin
        st_nxt = st_r;

        // Two-stage synchroniser plus edge delay
        st_nxt.sync1 = cnt_in;                                // [R15]
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;

        // Count step, the chain keeps going after overflow
        st_nxt.dig = dig_step;                                // [R1] [R5]

        // Overflow flip-flop set by the carry
        if (roll)
        begin
            st_nxt.half = 1'b1;                               // [R3]
        end

        // Carry drops for a fixed time after each wrap
        if (roll)
        begin
            st_nxt.carry     = 1'b0;                          // [R2] [R5]
            st_nxt.carry_cnt = bcdcnt_pkg::CARRY_LOAD;
        end
        else if (st_r.carry_cnt != '0)
        begin
            st_nxt.carry_cnt = st_r.carry_cnt - 1'b1;
            if (st_r.carry_cnt == 4'h1)
            begin
                st_nxt.carry = 1'b1;
            end
        end

        // Level clear wins over counting and overflow
        if (!clr_n)
        begin
            st_nxt.dig  = '0;                                 // [R14]
            st_nxt.half = 1'b0;                               // [R4]
        end

        // Output latches are open only while store is low
        if (!store_n)
        begin
            st_nxt.seg      = seg_dec;                        // [R8]
            st_nxt.half_seg = st_r.half;                      // [R3] [R8]
        end

        // Chain output high only with every digit dark
        st_nxt.lz_out = blank[0];                             // [R11] [R12]

        // Register writes
        if (reg_we)
        begin
            unique case (reg_addr)
                bcdcnt_pkg::REG_CTRL:
                begin
                    st_nxt.fmt = reg_wdata[bcdcnt_pkg::CTRL_FMT_BIT];
                end
                bcdcnt_pkg::REG_MASK:
                begin
                    st_nxt.mask = reg_wdata[bcdcnt_pkg::EV_W-1:0];
                end
                default:
                begin
                    st_nxt.mask = st_r.mask;
                end
            endcase
        end

        // Read data stands for one cycle only
        st_nxt.rdata = '0;
        if (reg_re)
        begin
            unique case (reg_addr)
                bcdcnt_pkg::REG_CTRL:
                begin
                    st_nxt.rdata[bcdcnt_pkg::CTRL_FMT_BIT] = st_r.fmt;
                end
                bcdcnt_pkg::REG_STATUS:
                begin
                    st_nxt.rdata[bcdcnt_pkg::EV_W-1:0] = st_r.status;
                end
                bcdcnt_pkg::REG_MASK:
                begin
                    st_nxt.rdata[bcdcnt_pkg::EV_W-1:0] = st_r.mask;
                end
                bcdcnt_pkg::REG_COUNT:
                begin
                    st_nxt.rdata = st_r.dig;
                end
                bcdcnt_pkg::REG_HALF:
                begin
                    st_nxt.rdata[0] = st_r.half;
                end
                default:
                begin
                    st_nxt.rdata = '0;
                end
            endcase
        end

        // Sticky status, a read clears and a new event wins
        if (reg_re && reg_addr == bcdcnt_pkg::REG_STATUS)
        begin
            st_nxt.status = ev;
        end
        else
        begin
            st_nxt.status = st_r.status | ev;
        end

        // Level interrupt from unmasked status
        st_nxt.irq = |(st_nxt.status & st_r.mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Asynchronous reset to constants only
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r           <= '0;
            st_r.carry     <= 1'b1;
            st_r.fmt       <= bcdcnt_pkg::CTRL_RST;
            st_r.mask      <= bcdcnt_pkg::MASK_RST;
            st_r.status    <= bcdcnt_pkg::STATUS_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Every output is a state flip-flop
    assign carry_out = st_r.carry;
    assign lz_out    = st_r.lz_out;
    assign seg_out   = st_r.seg;
    assign half_seg  = st_r.half_seg;
    assign reg_rdata = st_r.rdata;
    assign irq       = st_r.irq;

    // Pull-ups live at the pad; open pins arrive here as 1  [R13]

endmodule

// file: testbench/bcdcnt_checker.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker for the counter and display block
// ****************************************************************
module bcdcnt_checker
(
    input wire logic                          clk_sys,   // Clock
    input wire logic                          nrst,      // Reset
    input wire logic                          cnt_in,    // Count
    input wire logic                          hold_n,    // Hold
    input wire logic                          clr_n,     // Clear
    input wire logic                          store_n,   // Store
    input wire logic                          lz_in,     // Chain in
    input wire logic                          carry_out, // Carry
    input wire logic                          lz_out,    // Chain out
    input wire logic [bcdcnt_pkg::NDIG*7-1:0] seg_out,   // Segments
    input wire logic                          half_seg,  // Half digit
    input wire logic [bcdcnt_pkg::ADDR_W-1:0] reg_addr,  // Address
    input wire logic [bcdcnt_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic                          reg_we,    // Write
    input wire logic                          reg_re,    // Read
    input wire logic [bcdcnt_pkg::DATA_W-1:0] reg_rdata, // Read data
    input wire logic                          irq        // Interrupt
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Carry timing and cause
    a_carry_width: assert property
        ($fell(carry_out) |=> !carry_out [*3] ##1 carry_out)
        else $error("carry low time wrong");
    a_carry_cause: assert property
        ($fell(carry_out) |->
            !$past(cnt_in, 3) && $past(cnt_in, 4) && $past(hold_n))
        else $error("carry without counted fall");
    // Display latches and blanking chain
    a_seg_hold: assert property
        ($past(store_n) |-> $stable(seg_out) && $stable(half_seg))
        else $error("segments changed while stored");
    a_chain_low: assert property
        ($past(!lz_in && !store_n) |-> !lz_out)
        else $error("chain out high with chain in low");
    a_blank_all: assert property
        (lz_out && $past(!store_n) |-> seg_out == '0)
        else $error("chain out high with lit digit");
    a_half_unblank: assert property
        (half_seg && $past(!store_n) |-> !lz_out)
        else $error("chain out high with half digit");
    // Register port and interrupt
    a_rdata_idle: assert property
        (!$past(reg_re) |-> reg_rdata == '0)
        else $error("read data outside read cycle");
    a_irq_cause: assert property
        ($rose(irq) |-> $fell(carry_out) || $past(reg_we, 2))
        else $error("interrupt without event");
    a_irq_clear: assert property
        (reg_re && reg_addr == bcdcnt_pkg::REG_STATUS ##1 !$fell(carry_out)
            |-> !irq)
        else $error("interrupt stayed after status read");

    c_carry: cover property ($fell(carry_out));
    c_irq: cover property ($rose(irq));
    c_blank: cover property ($rose(lz_out));
    c_half: cover property ($rose(half_seg));
endmodule

// file: testbench/bcdcnt_pulse_src.sv
`timescale 1ns/1ps

// ****************************************************************
// Count pulse source on the far side of the count input
// ****************************************************************
module bcdcnt_pulse_src
(
    input  wire logic        clk_sys,  // Clock
    input  wire logic        start,    // Begin a burst
    input  wire logic [15:0] n_pulse,  // Pulses in burst
    input  wire logic [1:0]  half_len, // Cycles per level
    output logic             cnt_in,   // Count line
    output logic             busy      // Burst running
);
    // Line idles high; each level stands whole cycles so no fall is lost
    initial
    begin
        cnt_in = 1'b1;
        busy   = 1'b0;
        forever
        begin
            @(posedge clk_sys);
            if (start)
            begin
                busy <= 1'b1;
                repeat (n_pulse)
                begin
                    cnt_in <= 1'b0;
                    repeat (half_len) @(posedge clk_sys);
                    cnt_in <= 1'b1;
                    repeat (half_len) @(posedge clk_sys);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// file: testbench/bcdcnt_top_test.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench
// ****************************************************************
module bcdcnt_top_test;
    localparam logic [6:0] SEGS [10] = '{7'h7e, 7'h30, 7'h6d, 7'h79,
        7'h33, 7'h5b, 7'h5f, 7'h70, 7'h7f, 7'h7b};
    logic        clk_sys, nrst, cnt_in, hold_n, clr_n, store_n, lz_in;
    logic        reg_we, reg_re, carry_out, lz_out, half_seg, irq;
    logic        start, busy, carry_q, half_exp, half_now, fmt_exp;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, n_pulse, cnt_exp;
    logic [27:0] seg_out;
    logic [28:0] disp_now;
    logic [1:0]  half_len;
    logic [31:0] seed, r_val;
    int          failures, check_count, cycles, carries, carries_exp;

    bcdcnt_top dut_u
    (
        .clk_sys(clk_sys), .nrst(nrst), .cnt_in(cnt_in), .hold_n(hold_n),
        .clr_n(clr_n), .store_n(store_n), .lz_in(lz_in),
        .carry_out(carry_out), .lz_out(lz_out), .seg_out(seg_out),
        .half_seg(half_seg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq)
    );

    bcdcnt_pulse_src src_u
    (
        .clk_sys(clk_sys), .start(start), .n_pulse(n_pulse),
        .half_len(half_len), .cnt_in(cnt_in), .busy(busy)
    );

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Carry fall counter and hang limit
    always @(posedge clk_sys)
    begin
        cycles  <= cycles + 1;
        carry_q <= carry_out;
        if (nrst === 1'b1 && carry_q === 1'b1 && carry_out === 1'b0)
            carries <= carries + 1;
        if (cycles == 80000)
        begin
            failures = failures + 1;
            complete_run();
        end
    end

    // ****************************************************************
    // Expectation helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Next count with wrap flag on top; tens digits wrap after 5 in time mode
    function automatic logic [16:0] bcd_inc(logic [15:0] v);
        logic c;
        c = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (c && v[4*i+:4] == ((fmt_exp && i % 2 == 1) ? 4'h5 : 4'h9))
                v[4*i+:4] = 4'h0;
            else if (c)
            begin
                v[4*i+:4] = v[4*i+:4] + 4'h1;
                c = 1'b0;
            end
        end
        return {c, v};
    endfunction

    function automatic int to_wrap();
        logic [16:0] r;
        int          k;
        r = {1'b0, cnt_exp};
        k = 0;
        while (!r[16])
        begin
            r = bcd_inc(r[15:0]);
            k++;
        end
        return k;
    endfunction

    // Segments with leading zeros blanked from the top digit down
    function automatic logic [28:0] exp_disp(logic [15:0] v);
        logic [28:0] e;
        logic        run;
        run = lz_in & ~half_exp;
        for (int i = 3; i >= 0; i--)
        begin
            run = run & (v[4*i+:4] == 4'h0);
            e[7*i+:7] = run ? 7'h00 : SEGS[v[4*i+:4]];
        end
        e[28] = run;
        return e;
    endfunction

    // ****************************************************************
    // Driving and checking tasks
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, seen, want);
        end
    endtask

    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask

    task rdc(input logic [2:0] a, input logic [15:0] want);
        @(posedge clk_sys);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1;
        check(32'(reg_rdata), 32'(want));
    endtask

    task irq_chk(input logic want);
        @(posedge clk_sys);
        #1;
        check(32'(irq), 32'(want));
    endtask

    // Expectation is reckoned once the control levels have landed
    task burst(input int n, input logic [1:0] len);
        logic [16:0] r;
        @(posedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            if (hold_n === 1'b1 && clr_n === 1'b1)
            begin
                r = bcd_inc(cnt_exp);
                cnt_exp = r[15:0];
                carries_exp += int'(r[16]);
                half_exp |= r[16];
            end
        end
        n_pulse  <= 16'(n);
        half_len <= len;
        start    <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        @(posedge clk_sys);
        while (busy === 1'b1)
            @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
    endtask

    task disp_chk();
        @(posedge clk_sys);
        #1;
        if (!store_n)
        begin
            disp_now = exp_disp(cnt_exp);
            half_now = half_exp;
            check(32'(lz_out), 32'(disp_now[28]));
        end
        check(32'(seg_out), 32'(disp_now[27:0]));
        check(32'(half_seg), 32'(half_now));
    endtask

    // Pulses during clear must not step
    task clear_all();
        @(posedge clk_sys);
        clr_n   <= 1'b0;
        hold_n  <= 1'b1;
        store_n <= 1'b0;
        cnt_exp  = 16'h0;
        half_exp = 1'b0;
        burst(3, 2'h2);
        clr_n <= 1'b1;
    endtask

    task complete_run();
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        seed = 32'h7f95;
        {failures, check_count, cycles, carries, carries_exp} = '0;
        {nrst, reg_we, reg_re, start, half_exp, fmt_exp} = '0;
        {hold_n, clr_n, store_n, lz_in} = 4'hd;
        {reg_addr, reg_wdata, cnt_exp} = '0;
        n_pulse  = 16'h1;
        half_len = 2'h2;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++)
            rdc(3'(a), 16'h0);
        wr(bcdcnt_pkg::REG_COUNT, 16'h1234);
        rdc(bcdcnt_pkg::REG_COUNT, 16'h0);
        check(32'(carry_out), 32'h1);
        disp_chk();
        for (int i = 0; i < 16; i++)
        begin
            r_val = rnd();
            @(posedge clk_sys);
            hold_n  <= |r_val[1:0];
            lz_in   <= r_val[2];
            store_n <= r_val[3] & r_val[4];
            burst(int'(r_val[9:5]) + 1, 2'h2 + 2'(r_val[10]));
            rdc(bcdcnt_pkg::REG_COUNT, cnt_exp);
            disp_chk();
        end
        clear_all();
        rdc(bcdcnt_pkg::REG_COUNT, 16'h0);
        wr(bcdcnt_pkg::REG_CTRL, 16'h1);
        fmt_exp = 1'b1;
        wr(bcdcnt_pkg::REG_MASK, 16'h3);
        burst(to_wrap(), 2'h2);
        check(32'(carries), 32'(carries_exp));
        rdc(bcdcnt_pkg::REG_COUNT, 16'h0);
        rdc(bcdcnt_pkg::REG_HALF, 16'h1);
        disp_chk();
        irq_chk(1'b1);
        rdc(bcdcnt_pkg::REG_STATUS, 16'h3);
        irq_chk(1'b0);
        rdc(bcdcnt_pkg::REG_STATUS, 16'h0);
        wr(bcdcnt_pkg::REG_MASK, 16'h2);
        wr(bcdcnt_pkg::REG_CTRL, 16'h0);
        fmt_exp = 1'b0;
        burst(to_wrap(), 2'h2);
        check(32'(carries), 32'(carries_exp));
        irq_chk(1'b0);
        rdc(bcdcnt_pkg::REG_HALF, 16'h1);
        rdc(bcdcnt_pkg::REG_COUNT, 16'h0);
        wr(bcdcnt_pkg::REG_MASK, 16'h3);
        irq_chk(1'b1);
        rdc(bcdcnt_pkg::REG_STATUS, 16'h1);
        clear_all();
        rdc(bcdcnt_pkg::REG_HALF, 16'h0);
        disp_chk();
        complete_run();
    end
endmodule

bind bcdcnt_top bcdcnt_checker chk_u
(
    .clk_sys(clk_sys), .nrst(nrst), .cnt_in(cnt_in), .hold_n(hold_n),
    .clr_n(clr_n), .store_n(store_n), .lz_in(lz_in),
    .carry_out(carry_out), .lz_out(lz_out), .seg_out(seg_out),
    .half_seg(half_seg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq)
);
